// ### core/pmrc_clock_watch.sv
// lost clock detector: one-shot retriggered by core clock activity
`timescale 1ns/1ps
`default_nettype none
module pmrc_clock_watch #(
  parameter int TIMEOUT_CYC = pmrc_pkg::LOST_CLK_TIMEOUT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic sysclk_tick,
  output var  logic expired
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

  logic [CW-1:0] cnt;

  // ==========================================================================
  // each core clock edge retriggers the one-shot
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= '0;
      expired <= 1'b0;
    end else if (!enable || sysclk_tick) begin
      cnt     <= '0;
      expired <= 1'b0;
    end else if (cnt == LAST) begin
      expired <= 1'b1;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule // pmrc_clock_watch
`default_nettype wire

// ### core/pmrc_ctrl.sv
// power mode and reset control: idle/stop modes, reset merge and sequencing
`timescale 1ns/1ps
`default_nettype none
module pmrc_ctrl #(
  parameter int SUPPLY_TIMEOUT_CYC   = pmrc_pkg::SUPPLY_TIMEOUT_CYC,
  parameter int LOST_CLK_TIMEOUT_CYC = pmrc_pkg::LOST_CLK_TIMEOUT_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire pmrc_pkg::pmrc_sfr_req_s sfr_req,
  output var  logic [7:0]              sfr_rdata,
  input  wire logic                    instr_done,
  input  wire logic                    irq_pending,
  input  wire logic                    monitor_en,
  input  wire logic                    supply_ok,
  input  wire logic                    rst_pin_in,
  output var  logic                    rst_pin_out,
  output var  logic                    rst_pin_oe_n,
  input  wire logic                    convert_start_input_n,
  input  wire logic                    comp_low,
  input  wire logic                    wdt_overflow,
  input  wire logic                    lost_clock_enable,
  input  wire logic                    sysclk_tick,
  input  wire logic                    osc_stable,
  output var  logic                    core_rst,
  output var  logic [15:0]             pc_load_addr,
  output var  logic                    cpu_clk_en,
  output var  logic                    periph_clk_en,
  output var  logic                    osc_en,
  output var  logic                    port_latch_set,
  output var  logic                    weak_pullup_en,
  output var  logic                    idle_mode,
  output var  logic                    stop_mode
);
  localparam int CW = $clog2(SUPPLY_TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] SUPPLY_LAST  = CW'(SUPPLY_TIMEOUT_CYC - 1);
  localparam logic [CW-1:0] STRETCH_LAST = CW'(pmrc_pkg::PIN_STRETCH_CYC - 1);

  pmrc_pkg::pmrc_rst_state_e state;
  pmrc_pkg::pmrc_rst_state_e next_state;
  pmrc_pkg::pmrc_pwr_mode_e  mode;
  pmrc_pkg::pmrc_pwr_mode_e  next_mode;

  logic [CW-1:0]               cnt;
  logic [pmrc_pkg::RS_NUM-1:0] req_vec;
  logic [pmrc_pkg::RS_NUM-1:0] cause;
  logic [pmrc_pkg::RS_NUM-1:0] flags;
  logic [7:0]                  pwr_ctrl;
  logic [1:0]                  drive_hist;
  logic                        pin_high;
  logic                        mcd_expired;
  logic                        comp_en;
  logic                        cnv_en;
  logic                        any_req;
  logic                        supply_req;
  logic                        pc_wr;
  logic                        rs_wr;
  logic                        idle_arm;
  logic                        stop_arm;
  logic                        next_drive;

  // ==========================================================================
  // submodules
  pmrc_pin_sync u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   (rst_pin_in),
    .pin_high (pin_high)
  );

  pmrc_clock_watch #(
    .TIMEOUT_CYC (LOST_CLK_TIMEOUT_CYC)
  ) u_clock_watch (
    .clk         (clk),
    .rst         (rst),
    .enable      (lost_clock_enable),
    .sysclk_tick (sysclk_tick),
    .expired     (mcd_expired)
  );

  // ==========================================================================
  // register decode
  assign pc_wr = sfr_req.wr &&
                 pmrc_pkg::sfr_hit(sfr_req, pmrc_pkg::PWR_CTRL_ADDR);
  assign rs_wr = sfr_req.wr &&
                 pmrc_pkg::sfr_hit(sfr_req, pmrc_pkg::RST_SRC_ADDR);

  // ==========================================================================
  // reset request merge
  // monitor enable is expected to be tied high on the board
  assign supply_req = monitor_en && !supply_ok;

  always_comb begin
    req_vec = '0;
    req_vec[pmrc_pkg::RS_POR]  = supply_req ||
                                 (rs_wr && sfr_req.wdata[pmrc_pkg::RS_POR]);
    // our own drive takes two cycles to leave the synchroniser
    req_vec[pmrc_pkg::RS_PIN]  = !pin_high && rst_pin_oe_n &&
                                 !(|drive_hist);
    req_vec[pmrc_pkg::RS_MCD]  = mcd_expired &&
                                 state == pmrc_pkg::RST_RUN;
    req_vec[pmrc_pkg::RS_WDT]  = wdt_overflow;
    req_vec[pmrc_pkg::RS_SW]   = rs_wr && sfr_req.wdata[pmrc_pkg::RS_SW];
    req_vec[pmrc_pkg::RS_COMP] = comp_en && comp_low;
    req_vec[pmrc_pkg::RS_CNV]  = cnv_en && !convert_start_input_n;
  end

  assign any_req = |req_vec;

  // ==========================================================================
  // reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      pmrc_pkg::RST_RUN: begin
        if (any_req) begin
          next_state = pmrc_pkg::RST_HOLD;
        end
      end
      pmrc_pkg::RST_HOLD: begin
        if (!any_req) begin
          next_state = cause[pmrc_pkg::RS_POR] ? pmrc_pkg::RST_SUPPLY_WAIT
                                               : pmrc_pkg::RST_STRETCH;
        end
      end
      pmrc_pkg::RST_SUPPLY_WAIT: begin
        if (supply_req) begin
          next_state = pmrc_pkg::RST_HOLD;
        end else if (cnt == SUPPLY_LAST) begin
          next_state = pmrc_pkg::RST_STRETCH;
        end
      end
      pmrc_pkg::RST_STRETCH: begin
        if (any_req) begin
          next_state = pmrc_pkg::RST_HOLD;
        end else if (pin_high && cnt == STRETCH_LAST) begin
          next_state = pmrc_pkg::RST_OSC_WAIT;
        end
      end
      pmrc_pkg::RST_OSC_WAIT: begin
        if (any_req) begin
          next_state = pmrc_pkg::RST_HOLD;
        end else if (osc_stable) begin
          next_state = pmrc_pkg::RST_RUN;
        end
      end
      default: begin
        next_state = pmrc_pkg::RST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= pmrc_pkg::RST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // shared counter: supply timeout, then pin stretch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (next_state != state) begin
      cnt <= '0;
    end else if (state == pmrc_pkg::RST_STRETCH && !pin_high) begin
      cnt <= '0;
    end else if (state == pmrc_pkg::RST_SUPPLY_WAIT ||
                 state == pmrc_pkg::RST_STRETCH) begin
      cnt <= cnt + CW'(1);
    end
  end

  // ==========================================================================
  // reset cause and source flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause <= pmrc_pkg::CAUSE_AT_POWERUP;
    end else if (next_state == pmrc_pkg::RST_RUN) begin
      cause <= '0;
    end else begin
      cause <= cause | req_vec;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= pmrc_pkg::FLAGS_RESET;
    end else if (state != pmrc_pkg::RST_RUN &&
                 next_state == pmrc_pkg::RST_RUN) begin
      // every reset exit replaces all flag bits with the latched cause, power-on included
      flags <= cause;
    end
  end

  // ==========================================================================
  // reset pin drive and core side reset outputs
  assign next_drive = next_state == pmrc_pkg::RST_SUPPLY_WAIT ||
                      (next_state == pmrc_pkg::RST_HOLD &&
                       (cause[pmrc_pkg::RS_POR] || req_vec[pmrc_pkg::RS_POR]));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_pin_out  <= 1'b0;
      rst_pin_oe_n <= 1'b0;
      drive_hist   <= 2'h3;
    end else begin
      rst_pin_out  <= 1'b0;
      rst_pin_oe_n <= !next_drive;
      drive_hist   <= {drive_hist[0], !rst_pin_oe_n};
    end
  end

  // data memory has no reset path here; the core resets its stack pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_rst       <= 1'b1;
      port_latch_set <= 1'b1;
      weak_pullup_en <= 1'b0;
      pc_load_addr   <= pmrc_pkg::RESET_VECTOR;
    end else begin
      core_rst       <= next_state != pmrc_pkg::RST_RUN;
      port_latch_set <= next_state != pmrc_pkg::RST_RUN;
      weak_pullup_en <= next_state == pmrc_pkg::RST_RUN;
      pc_load_addr   <= pmrc_pkg::RESET_VECTOR;
    end
  end

  // ==========================================================================
  // register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_ctrl <= pmrc_pkg::PWR_CTRL_RESET;
      comp_en  <= 1'b0;
      cnv_en   <= 1'b0;
    end else if (state != pmrc_pkg::RST_RUN) begin
      pwr_ctrl <= pmrc_pkg::PWR_CTRL_RESET;
      comp_en  <= 1'b0;
      cnv_en   <= 1'b0;
    end else begin
      if (pc_wr) begin
        // mode select bits are not stored, so they always read zero
        pwr_ctrl <= sfr_req.wdata & pmrc_pkg::PWR_CTRL_KEEP;
      end
      if (rs_wr) begin
        comp_en <= sfr_req.wdata[pmrc_pkg::RS_COMP];
        cnv_en  <= sfr_req.wdata[pmrc_pkg::RS_CNV];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (!sfr_req.rd) begin
      sfr_rdata <= 8'h00;
    end else if (pmrc_pkg::sfr_hit(sfr_req, pmrc_pkg::PWR_CTRL_ADDR)) begin
      sfr_rdata <= pwr_ctrl;
    end else if (pmrc_pkg::sfr_hit(sfr_req, pmrc_pkg::RST_SRC_ADDR)) begin
      sfr_rdata <= {1'b0, flags};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // power modes
  assign idle_arm = pc_wr && sfr_req.wdata[pmrc_pkg::PC_IDLE_BIT];
  assign stop_arm = pc_wr && sfr_req.wdata[pmrc_pkg::PC_STOP_BIT];

  logic idle_pend;
  logic stop_pend;

  // the write lands mid-instruction; entry waits for it to complete
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_pend <= 1'b0;
      stop_pend <= 1'b0;
    end else if (next_state != pmrc_pkg::RST_RUN || instr_done) begin
      idle_pend <= 1'b0;
      stop_pend <= 1'b0;
    end else begin
      idle_pend <= idle_pend || idle_arm;
      stop_pend <= stop_pend || stop_arm;
    end
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      pmrc_pkg::PWR_ACTIVE: begin
        if (instr_done && (stop_pend || stop_arm)) begin
          next_mode = pmrc_pkg::PWR_STOP;
        end else if (instr_done && (idle_pend || idle_arm)) begin
          next_mode = pmrc_pkg::PWR_IDLE;
        end
      end
      pmrc_pkg::PWR_IDLE: begin
        // core resumes into the handler; its return lands after the write
        if (irq_pending) begin
          next_mode = pmrc_pkg::PWR_ACTIVE;
        end
      end
      pmrc_pkg::PWR_STOP: begin
        next_mode = pmrc_pkg::PWR_STOP;
      end
      default: begin
        next_mode = pmrc_pkg::PWR_ACTIVE;
      end
    endcase
    if (next_state != pmrc_pkg::RST_RUN) begin
      next_mode = pmrc_pkg::PWR_ACTIVE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode          <= pmrc_pkg::PWR_ACTIVE;
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en        <= 1'b1;
      idle_mode     <= 1'b0;
      stop_mode     <= 1'b0;
    end else begin
      mode          <= next_mode;
      cpu_clk_en    <= next_mode == pmrc_pkg::PWR_ACTIVE;
      // watchdog keeps its clock while idle
      periph_clk_en <= next_mode != pmrc_pkg::PWR_STOP;
      osc_en        <= next_mode != pmrc_pkg::PWR_STOP;
      idle_mode     <= next_mode == pmrc_pkg::PWR_IDLE;
      stop_mode     <= next_mode == pmrc_pkg::PWR_STOP;
    end
  end

  // ==========================================================================
  // assertions
  idle_clock_a: assert property (@(posedge clk) disable iff (rst)
    mode == pmrc_pkg::PWR_IDLE |-> !cpu_clk_en && periph_clk_en)
    else $error("idle must stop cpu clock only");

  idle_wake_a: assert property (@(posedge clk) disable iff (rst)
    mode == pmrc_pkg::PWR_IDLE && irq_pending |=> cpu_clk_en && !idle_mode)
    else $error("interrupt did not end idle");

  stop_exit_a: assert property (@(posedge clk) disable iff (rst)
    mode == pmrc_pkg::PWR_STOP && !any_req |=> stop_mode && !osc_en)
    else $error("stop left without reset");

  read_zero_a: assert property (@(posedge clk) disable iff (rst)
    sfr_req.rd && pmrc_pkg::sfr_hit(sfr_req, pmrc_pkg::PWR_CTRL_ADDR)
    |=> sfr_rdata[1:0] == 2'b00)
    else $error("mode select bits read nonzero");

  pull_up_a: assert property (@(posedge clk) disable iff (rst)
    core_rst |-> port_latch_set && !weak_pullup_en)
    else $error("pull-ups enabled during reset");

  supply_drive_a: assert property (@(posedge clk) disable iff (rst)
    state == pmrc_pkg::RST_SUPPLY_WAIT |-> !rst_pin_oe_n)
    else $error("pin released during supply timeout");

  supply_hold_a: assert property (@(posedge clk) disable iff (rst)
    supply_req |=> core_rst ##1 core_rst)
    else $error("low supply did not hold reset");

  por_flag_a: assert property (@(posedge clk) disable iff (rst)
    $fell(core_rst) |->
    flags[pmrc_pkg::RS_POR] == $past(cause[pmrc_pkg::RS_POR]))
    else $error("power-on flag wrong at reset exit");

  pin_stretch_a: assert property (@(posedge clk) disable iff (rst)
    $fell(core_rst) |-> $past(pin_high) && $past(pin_high, 12))
    else $error("reset released too soon after pin");

  lost_clock_a: assert property (@(posedge clk) disable iff (rst)
    req_vec[pmrc_pkg::RS_MCD] && !req_vec[pmrc_pkg::RS_POR]
    && !cause[pmrc_pkg::RS_POR] |=> core_rst && rst_pin_oe_n)
    else $error("lost clock reset wrong");

endmodule // pmrc_ctrl
`default_nettype wire

// ### core/pmrc_pin_sync.sv
// two-stage synchroniser for the active-low external reset pin
`timescale 1ns/1ps
`default_nettype none
module pmrc_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output var  logic pin_high
);
  logic stage1;

  // ==========================================================================
  // sync chain; pin idles high so both stages reset to one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1   <= 1'b1;
      pin_high <= 1'b1;
    end else begin
      stage1   <= pin_in;
      pin_high <= stage1;
    end
  end
endmodule // pmrc_pin_sync
`default_nettype wire

// ### core/pmrc_pkg.sv
// shared constants, types and helpers for the power mode and reset control
package pmrc_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS        = 5;
  localparam int SUPPLY_TIMEOUT_MS    = 100;
  localparam int SUPPLY_TIMEOUT_CYC   =
    SUPPLY_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOST_CLK_TIMEOUT_US  = 100;
  localparam int LOST_CLK_TIMEOUT_CYC =
    LOST_CLK_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int PIN_STRETCH_CYC      = 12;

  // ==========================================================================
  // special function register map
  localparam logic [7:0]  PWR_CTRL_ADDR   = 8'h87;
  localparam logic [7:0]  PWR_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  PWR_CTRL_KEEP   = 8'hd8;
  localparam int          PC_IDLE_BIT     = 0;
  localparam int          PC_STOP_BIT     = 1;
  localparam logic [7:0]  RST_SRC_ADDR    = 8'hef;
  localparam int          RS_PIN          = 0;
  localparam int          RS_POR          = 1;
  localparam int          RS_MCD          = 2;
  localparam int          RS_WDT          = 3;
  localparam int          RS_SW           = 4;
  localparam int          RS_COMP         = 5;
  localparam int          RS_CNV          = 6;
  localparam int          RS_NUM          = 7;
  localparam logic [6:0]  CAUSE_AT_POWERUP = 7'h02;
  localparam logic [6:0]  FLAGS_RESET      = 7'h00;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmrc_sfr_req_s;

  typedef enum logic [2:0] {
    RST_HOLD, RST_SUPPLY_WAIT, RST_STRETCH, RST_OSC_WAIT, RST_RUN
  } pmrc_rst_state_e;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_IDLE, PWR_STOP
  } pmrc_pwr_mode_e;

  function automatic logic sfr_hit(pmrc_sfr_req_s req, logic [7:0] addr);
    sfr_hit = (req.addr == addr);
  endfunction

endpackage

// ### tb/pmrc_board.sv
// board side model: reset pin with pull-up and the supply monitor
`timescale 1ns/1ps
`default_nettype none
module pmrc_board (
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  input  wire logic push_low,
  input  wire logic vdd_good,
  output var  logic pin_level,
  output var  logic supply_ok,
  output var  logic monitor_en
);
  // ==========================================================================
  // wired pin
  // pull-up holds the line high when nobody drives it
  assign pin_level  = !push_low & (pin_oe_n | pin_out);
  assign supply_ok  = vdd_good;
  assign monitor_en = 1'h1;
endmodule // pmrc_board
`default_nettype wire

// ### tb/tb_pmrc_ctrl.sv
// self-checking bench for the power mode and reset control
`timescale 1ns/1ps
`default_nettype none
module tb_pmrc_ctrl;
  // ==========================================================================
  // stimulus and hookup
  typedef struct packed {
    logic [2:0] kind;
    logic [7:0] flag;
    logic [7:0] fmask;
    logic [7:0] rst_st;
  } pmrc_row_s;

  logic clk = 1'h0;
  logic rst = 1'h1;
  pmrc_pkg::pmrc_sfr_req_s req = '0;
  logic        fin = 1'h0, irq = 1'h0, push_low = 1'h0, vdd = 1'h1;
  logic        cnv_n = 1'h1, comp = 1'h0, wdt = 1'h0, lce = 1'h0;
  logic        tick = 1'h1, osc = 1'h1;
  logic [7:0]  rdata;
  logic [15:0] pc;
  logic        pin_out, oe_n, pin_lvl, sup_ok, mon_en, core_rst;
  logic        cpu_en, per_en, osc_en, latch, pull, idle, stop;
  int          errors = 0;
  int          compares = 0;

  // kind, expected flags, flag mask, status in reset {latch,pull,oe_n}
  pmrc_row_s rows[7] = '{
    '{3'h0, 8'h01, 8'hff, 8'h05}, '{3'h1, 8'h10, 8'hff, 8'h05},
    '{3'h2, 8'h08, 8'hff, 8'h05}, '{3'h3, 8'h20, 8'hff, 8'h05},
    '{3'h4, 8'h40, 8'hff, 8'h05}, '{3'h5, 8'h04, 8'hff, 8'h05},
    '{3'h6, 8'h02, 8'h02, 8'h04}};

  always #2.5 clk = ~clk;

  pmrc_ctrl #(.SUPPLY_TIMEOUT_CYC(20), .LOST_CLK_TIMEOUT_CYC(16)) i_pmrc_ctrl (
    .clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
    .instr_done(fin), .irq_pending(irq), .monitor_en(mon_en),
    .supply_ok(sup_ok), .rst_pin_in(pin_lvl), .rst_pin_out(pin_out),
    .rst_pin_oe_n(oe_n), .convert_start_input_n(cnv_n), .comp_low(comp),
    .wdt_overflow(wdt), .lost_clock_enable(lce), .sysclk_tick(tick),
    .osc_stable(osc), .core_rst(core_rst), .pc_load_addr(pc),
    .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .osc_en(osc_en),
    .port_latch_set(latch), .weak_pullup_en(pull), .idle_mode(idle),
    .stop_mode(stop));

  pmrc_board i_pmrc_board (
    .pin_out(pin_out), .pin_oe_n(oe_n), .push_low(push_low),
    .vdd_good(vdd), .pin_level(pin_lvl), .supply_ok(sup_ok),
    .monitor_en(mon_en));

  // ==========================================================================
  // tasks
  task automatic finish_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input logic [7:0] m);
    compares++;
    if ((got & m) !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got & m, exp);
    end
  endtask

  function automatic logic [7:0] st();
    return {stop, idle, osc_en, per_en, cpu_en, latch, pull, oe_n};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic f);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'h1;
    fin = f;
    cyc(1);
    req.wr = 1'h0;
    fin = 1'h0;
  endtask

  // read data is registered, so it shows in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req.addr = a;
    req.rd = 1'h1;
    cyc(1);
    d = rdata;
    req.rd = 1'h0;
  endtask

  task automatic wait_core(input logic lvl, output int n);
    n = 0;
    while (core_rst !== lvl) begin
      if (n == 300) begin
        errors++;
        finish_test;
      end
      cyc(1);
      n++;
    end
  endtask

  task automatic kick(input logic [2:0] k);
    case (k)
      3'h0: push_low = 1'h1;
      3'h1: wr(8'hef, 8'h10, 1'h0);
      3'h2: begin
        wr(8'h87, 8'h01, 1'h1);
        wdt = 1'h1;
      end
      3'h3: begin
        wr(8'hef, 8'h20, 1'h0);
        comp = 1'h1;
      end
      3'h4: begin
        wr(8'hef, 8'h40, 1'h0);
        cnv_n = 1'h0;
      end
      3'h5: begin
        lce = 1'h1;
        tick = 1'h0;
      end
      default: vdd = 1'h0;
    endcase
  endtask

  // ==========================================================================
  // sequence
  initial begin
    int n;
    logic [7:0] d;
    cyc(3);
    chk(st(), 8'h04, 8'h07);
    rst = 1'h0;
    wait_core(1'h0, n);
    chk(8'(n >= 32), 8'h01, 8'hff);
    rd(8'hef, d);
    chk(d, 8'h02, 8'h02);
    foreach (rows[i]) begin
      kick(rows[i].kind);
      wait_core(1'h1, n);
      cyc(2);
      chk(st(), rows[i].rst_st, 8'h07);
      {push_low, wdt, comp, lce} = 4'h0;
      {cnv_n, tick, vdd} = 3'h7;
      wait_core(1'h0, n);
      if (rows[i].kind == 3'h0) chk(8'(n >= 12), 8'h01, 8'hff);
      chk(st(), 8'h0a, 8'hce);
      chk(pc[15:8] | pc[7:0], 8'h00, 8'hff);
      rd(8'hef, d);
      chk(d, rows[i].flag, rows[i].fmask);
    end
    // reserved bits never read back
    foreach (rows[i]) begin
      wr(8'h87, 8'hdc ^ {rows[i].kind, 5'h0}, 1'h0);
      rd(8'h87, d);
      chk(d, (8'hdc ^ {rows[i].kind, 5'h0}) & 8'hd8, 8'hff);
    end
    cyc(1);
    rd(8'h55, d);
    chk(d, 8'h00, 8'hff);
    wr(8'h87, 8'h91, 1'h1);
    cyc(1);
    chk(st(), 8'h50, 8'h58);
    rd(8'h87, d);
    chk(d, 8'h90, 8'hff);
    irq = 1'h1;
    cyc(2);
    chk(st(), 8'h08, 8'h48);
    irq = 1'h0;
    wr(8'h87, 8'h02, 1'h1);
    cyc(1);
    chk(st(), 8'h80, 8'ha8);
    irq = 1'h1;
    osc = 1'h0;
    cyc(3);
    chk(st(), 8'h80, 8'h88);
    irq = 1'h0;
    push_low = 1'h1;
    wait_core(1'h1, n);
    cyc(2);
    push_low = 1'h0;
    // oscillator still settling, so the core must stay in reset
    cyc(30);
    chk(8'(core_rst), 8'h01, 8'hff);
    chk(st(), 8'h20, 8'h20);
    osc = 1'h1;
    wait_core(1'h0, n);
    chk(st(), 8'h08, 8'hc8);
    // lost clock ends stop without touching the pin
    wr(8'h87, 8'h02, 1'h1);
    cyc(1);
    {lce, tick} = 2'h2;
    wait_core(1'h1, n);
    chk(8'(n >= 16), 8'h01, 8'hff);
    chk(st(), 8'h05, 8'h07);
    {lce, tick} = 2'h1;
    wait_core(1'h0, n);
    rd(8'hef, d);
    chk(d, 8'h04, 8'hff);
    finish_test;
  end
endmodule // tb_pmrc_ctrl
`default_nettype wire
